// >>> reset_strap_and_pin_function.sv
// reset pin, strap capture and pin function selection of the device
module reset_strap_and_pin_function
  import pin_function_pkg::*;
#(
  parameter int AD_WIDTH = 16
)
(
  input wire logic mclk, // system clock, 20 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic internal_reset_req, // internal reset source, active high
  input wire logic reset_pin_n_in, // reset pin level
  output logic reset_pin_n_out, // reset pin drive value
  output logic reset_pin_n_oe, // reset pin drive enable
  output logic chip_in_reset, // device held in reset
  input wire logic pll_select, // request to leave the oscillator clock
  output logic clk_from_osc, // internal clocks taken from oscillator input
  output logic [2:0] mode, // captured mode C, B, A
  output logic osc_select, // captured oscillator select
  output logic flash_map_enable, // captured flash map enable
  output logic pe7_pullup_en, // pull-up on oscillator select strap
  input wire logic background_debug_pin, // background pin level
  input wire logic [15:0] ext_ad_out, // external address/data to drive
  input wire logic ext_ad_drive, // drive address/data onto ports A, B
  input wire logic ext_rw, // bus direction, 1 read
  input wire logic ext_low_byte_strobe_n, // low byte strobe from bus unit
  input wire logic bus_idle, // processor not using the bus
  input wire logic bus_clk_level, // internal bus clock level
  input wire logic [1:0] queue_track, // queue tracking 1, 0
  input wire logic emul_cs_n, // emulation chip select from bus unit
  input wire logic free_cycle_en, // enable free cycle indicator
  input wire logic queue_track_en, // enable queue tracking outputs
  input wire logic bus_clock_out_en, // enable bus clock output
  input wire logic tag_en, // instruction tagging on
  output logic tag_high_mark, // high half tagged, pulse
  output logic tag_low_mark, // low half tagged, pulse
  input wire logic [7:0] pa_in, // port A pin levels
  output logic [7:0] pa_out, // port A drive values
  output logic [7:0] pa_oe, // port A drive enables
  input wire logic [7:0] pb_in, // port B pin levels
  output logic [7:0] pb_out, // port B drive values
  output logic [7:0] pb_oe, // port B drive enables
  input wire logic [7:0] gpio_ab_out, // general output, 8 bits, unused; ports A, B take gpio_ab_val
  input wire logic [15:0] gpio_ab_dir, // general direction, 1 output
  input wire logic [15:0] gpio_ab_val, // general values A (15:8), B (7:0)
  output logic [15:0] port_ab_rd, // ports A, B levels read back
  input wire logic [7:0] pe_in, // port E pin levels
  output logic [7:0] pe_out, // port E drive values
  output logic [7:0] pe_oe, // port E drive enables
  input wire logic [7:0] gpio_e_out, // general output port E
  input wire logic [7:0] gpio_e_dir, // general direction port E
  output logic [7:0] port_e_rd, // port E levels read back
  output logic irq_request, // maskable request level
  output logic nonmaskable_int_request_request, // non-maskable request level
  output logic wake_request, // wake from stop or wait
  input wire logic [7:0] ph_in, // port H pin levels
  output logic [7:0] ph_out, // port H drive values
  output logic [7:0] ph_oe, // port H drive enables
  input wire logic [7:0] gpio_h_out, // general output port H
  input wire logic [7:0] gpio_h_dir, // general direction port H
  input wire logic serial_periph_unit_2_en, // serial unit 2 owns pins 7..4
  input wire logic serial_periph_unit_1_en, // serial unit 1 owns pins 3..0
  input wire logic [3:0] serial_periph_unit_2_pin_out, // unit 2 ss, clock, mosi, miso values
  input wire logic [3:0] serial_periph_unit_2_pin_oe, // unit 2 drive enables
  input wire logic [3:0] serial_periph_unit_1_pin_out, // unit 1 values
  input wire logic [3:0] serial_periph_unit_1_pin_oe, // unit 1 drive enables
  output logic [7:0] port_h_rd, // port H levels read back
  input wire logic [3:0] pj_in, // port J pins 7, 6, 1, 0
  output logic [3:0] pj_out, // port J drive values
  output logic [3:0] pj_oe, // port J drive enables
  input wire logic [3:0] gpio_j_out, // general output port J
  input wire logic [3:0] gpio_j_dir, // general direction port J
  input wire logic can4_en, // CAN unit 4 owns pins 7, 6
  input wire logic can_tx, // CAN unit 4 transmit level
  input wire logic i2c_en, // I2C owns pins 7, 6
  input wire logic i2c_scl_low, // I2C pulls clock low
  input wire logic i2c_sda_low, // I2C pulls data low
  output logic [3:0] port_j_rd, // port J levels read back
  input wire logic [KEY_WAKE_COUNT-1:0] key_wake_en, // wake enable per pin
  input wire logic [KEY_WAKE_COUNT-1:0] key_wake_rising, // 1 rising, 0 falling edge
  input wire logic [KEY_WAKE_COUNT-1:0] key_wake_clear, // clear flag, pulse
  output logic [KEY_WAKE_COUNT-1:0] key_wake_flag, // sticky wake flags
  input wire logic pk7_in, // port K pin 7 level
  output logic pk7_out, // port K pin 7 drive value
  output logic pk7_oe, // port K pin 7 drive enable
  input wire logic gpio_k7_out, // general output port K pin 7
  input wire logic gpio_k7_dir, // general direction port K pin 7
  input wire logic [AD_WIDTH-1:0] pad_in, // port AD digital levels
  input wire logic [AD_WIDTH-1:0] pad_digital_en, // digital input enable
  output logic [AD_WIDTH-1:0] port_ad_rd // port AD levels read back
);

  function automatic logic is_expanded(input logic [2:0] m);
    is_expanded = (m == MODE_EMUL_NARROW) || (m == MODE_EMUL_WIDE) || (m == MODE_SPECIAL_TEST)
      || (m == MODE_NORMAL_NARROW) || (m == MODE_NORMAL_WIDE);
  endfunction

  function automatic logic flash_map_for(input logic [2:0] m, input logic strap);
    unique case (m)
      MODE_SPECIAL_SINGLE, MODE_NORMAL_SINGLE, MODE_PERIPH_TEST: flash_map_for = 1'b1;
      MODE_EMUL_WIDE, MODE_EMUL_NARROW, MODE_SPECIAL_TEST: flash_map_for = 1'b0;
      MODE_NORMAL_NARROW, MODE_NORMAL_WIDE: flash_map_for = strap;
    endcase
  endfunction

  logic reset_active;
  logic release_edge;
  logic expanded;
  logic bus_clk_prev;
  logic bus_clk_fall;
  logic [2:0] next_mode;
  logic [KEY_WAKE_COUNT-1:0] kw_pins;
  logic [KEY_WAKE_COUNT-1:0] kw_prev;
  logic [KEY_WAKE_COUNT-1:0] kw_event;

  // the pin reads back our own drive, so an internal reset also shows here
  assign reset_active = !reset_pin_n_in || internal_reset_req;
  assign release_edge = chip_in_reset && !reset_active;
  assign expanded = is_expanded(mode);
  assign bus_clk_fall = bus_clk_prev && !bus_clk_level;
  assign next_mode = {background_debug_pin, pe_in[PE_QUEUE_1], pe_in[PE_QUEUE_0]};
  assign kw_pins = {ph_in, pj_in};

  // reset pin drive and reset state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      reset_pin_n_out <= 1'b0;
      reset_pin_n_oe <= 1'b1;
      chip_in_reset <= 1'b1;
      pe7_pullup_en <= 1'b1;
      clk_from_osc <= 1'b1;
    end
    else
    begin
      reset_pin_n_out <= 1'b0; // see R1
      reset_pin_n_oe <= internal_reset_req; // see R1
      chip_in_reset <= reset_active; // see R1
      pe7_pullup_en <= reset_active; // see R5
      clk_from_osc <= reset_active || !pll_select; // see R2
    end
  end

  // straps, taken once at release and then frozen
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mode <= MODE_RESET;
      osc_select <= OSC_SELECT_RESET;
      flash_map_enable <= FLASH_MAP_RESET;
    end
    else if (release_edge) // see R22
    begin
      mode <= next_mode; // see R3
      osc_select <= pe_in[PE_FREE_CYCLE]; // see R4
      flash_map_enable <= flash_map_for(next_mode, pk7_in); // see R17 R18
    end
  end

  // ports A and B; pins float while in reset so straps are not fought
  always_ff @(posedge mclk)
  begin
    if (sys_rst || chip_in_reset)
    begin
      pa_out <= 8'h00;
      pa_oe <= 8'h00;
      pb_out <= 8'h00;
      pb_oe <= 8'h00;
    end
    else if (expanded)
    begin
      pa_out <= ext_ad_out[15:8]; // see R11
      pa_oe <= {8{ext_ad_drive}}; // see R11
      pb_out <= ext_ad_out[7:0]; // see R11
      pb_oe <= {8{ext_ad_drive}}; // see R11
    end
    else
    begin
      pa_out <= gpio_ab_val[15:8];
      pa_oe <= gpio_ab_dir[15:8];
      pb_out <= gpio_ab_val[7:0];
      pb_oe <= gpio_ab_dir[7:0];
    end
  end

  // port E; alternate function beats general use on each pin
  always_ff @(posedge mclk)
  begin
    if (sys_rst || chip_in_reset)
    begin
      pe_out <= 8'h00;
      pe_oe <= 8'h00;
    end
    else
    begin
      pe_out <= gpio_e_out;
      pe_oe <= gpio_e_dir;
      if (expanded && free_cycle_en) // see R23
      begin
        pe_out[PE_FREE_CYCLE] <= bus_idle; // see R8
        pe_oe[PE_FREE_CYCLE] <= 1'b1;
      end
      if (queue_track_en)
      begin
        pe_out[PE_QUEUE_1] <= queue_track[1]; // see R16
        pe_out[PE_QUEUE_0] <= queue_track[0]; // see R16
        pe_oe[PE_QUEUE_1] <= 1'b1;
        pe_oe[PE_QUEUE_0] <= 1'b1;
      end
      if (bus_clock_out_en)
      begin
        pe_out[PE_BUS_CLOCK] <= bus_clk_level; // see R15
        pe_oe[PE_BUS_CLOCK] <= 1'b1;
      end
      // tagging needs the pin as input, so it wins over the strobe
      if (expanded)
      begin
        pe_out[PE_STROBE] <= ext_low_byte_strobe_n; // see R9
        pe_oe[PE_STROBE] <= !tag_en; // see R7 R9
        pe_out[PE_RW] <= ext_rw; // see R10
        pe_oe[PE_RW] <= 1'b1;
      end
      pe_out[PE_IRQ] <= 1'b0;
      pe_oe[PE_IRQ] <= 1'b0;
      pe_out[PE_NONMASKABLE_INT_REQUEST] <= 1'b0;
      pe_oe[PE_NONMASKABLE_INT_REQUEST] <= 1'b0;
    end
  end

  // instruction tag sampling on the bus clock falling edge
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bus_clk_prev <= 1'b0;
      tag_high_mark <= 1'b0;
      tag_low_mark <= 1'b0;
    end
    else
    begin
      bus_clk_prev <= bus_clk_level;
      tag_high_mark <= expanded && tag_en && bus_clk_fall && !background_debug_pin; // see R6
      tag_low_mark <= expanded && tag_en && bus_clk_fall && !pe_in[PE_STROBE]; // see R7
    end
  end

  // ports H, J and K pin 7
  always_ff @(posedge mclk)
  begin
    if (sys_rst || chip_in_reset)
    begin
      ph_out <= 8'h00;
      ph_oe <= 8'h00;
      pj_out <= 4'h0;
      pj_oe <= 4'h0;
      pk7_out <= 1'b0;
      pk7_oe <= 1'b0;
    end
    else
    begin
      ph_out[7:4] <= serial_periph_unit_2_en ? serial_periph_unit_2_pin_out : gpio_h_out[7:4]; // see R19
      ph_oe[7:4] <= serial_periph_unit_2_en ? serial_periph_unit_2_pin_oe : gpio_h_dir[7:4]; // see R19
      ph_out[3:0] <= serial_periph_unit_1_en ? serial_periph_unit_1_pin_out : gpio_h_out[3:0]; // see R19
      ph_oe[3:0] <= serial_periph_unit_1_en ? serial_periph_unit_1_pin_oe : gpio_h_dir[3:0]; // see R19
      pj_out[1:0] <= gpio_j_out[1:0];
      pj_oe[1:0] <= gpio_j_dir[1:0];
      // fixed order: CAN before I2C before general use
      if (can4_en) // see R20 R23
      begin
        pj_out[PJ_PIN7] <= can_tx;
        pj_oe[PJ_PIN7] <= 1'b1;
        pj_out[PJ_PIN6] <= 1'b0;
        pj_oe[PJ_PIN6] <= 1'b0;
      end
      else if (i2c_en) // see R20
      begin
        pj_out[PJ_PIN7] <= 1'b0;
        pj_oe[PJ_PIN7] <= i2c_scl_low;
        pj_out[PJ_PIN6] <= 1'b0;
        pj_oe[PJ_PIN6] <= i2c_sda_low;
      end
      else
      begin
        pj_out[3:2] <= gpio_j_out[3:2];
        pj_oe[3:2] <= gpio_j_dir[3:2];
      end
      pk7_out <= expanded ? emul_cs_n : gpio_k7_out; // see R17
      pk7_oe <= expanded ? 1'b1 : gpio_k7_dir; // see R17
    end
  end

  // pin read back and interrupt request levels
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      port_ab_rd <= 16'h0000;
      port_e_rd <= 8'h00;
      port_h_rd <= 8'h00;
      port_j_rd <= 4'h0;
      port_ad_rd <= '0;
      irq_request <= 1'b0;
      nonmaskable_int_request_request <= 1'b0;
      wake_request <= 1'b0;
    end
    else
    begin
      port_ab_rd <= {pa_in, pb_in};
      port_e_rd <= pe_in;
      port_h_rd <= ph_in;
      port_j_rd <= pj_in;
      // analog path bypasses this block; only digital reads gated here
      port_ad_rd <= pad_in & pad_digital_en; // see R21
      irq_request <= !pe_in[PE_IRQ]; // see R12
      nonmaskable_int_request_request <= !pe_in[PE_NONMASKABLE_INT_REQUEST]; // see R13
      wake_request <= !pe_in[PE_IRQ] || !pe_in[PE_NONMASKABLE_INT_REQUEST] || (|key_wake_flag); // see R12 R13 R14
    end
  end

  // key wake flags; a new edge beats a clear in the same cycle
  genvar k;
  generate
    for (k = 0; k < KEY_WAKE_COUNT; k++)
    begin : g_key_wake
      assign kw_event[k] = key_wake_en[k] && (key_wake_rising[k] ? (!kw_prev[k] && kw_pins[k])
        : (kw_prev[k] && !kw_pins[k]));
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          kw_prev[k] <= 1'b0;
          key_wake_flag[k] <= 1'b0;
        end
        else
        begin
          kw_prev[k] <= kw_pins[k];
          if (kw_event[k])
            key_wake_flag[k] <= 1'b1; // see R14
          else if (key_wake_clear[k])
            key_wake_flag[k] <= 1'b0;
        end
      end
    end
  endgenerate

  mode_capture_a: assert property ( // see R3
    @(posedge mclk) disable iff (sys_rst) release_edge |=> mode == $past(next_mode))
    else $error("mode not captured at reset release");

  osc_capture_a: assert property ( // see R4
    @(posedge mclk) disable iff (sys_rst) release_edge |=> osc_select == $past(pe_in[PE_FREE_CYCLE]))
    else $error("oscillator select not captured");

  strap_hold_a: assert property ( // see R22
    @(posedge mclk) disable iff (sys_rst)
    !release_edge |=> $stable(mode) && $stable(osc_select) && $stable(flash_map_enable))
    else $error("strap changed outside reset release");

  flash_map_a: assert property ( // see R18
    @(posedge mclk) disable iff (sys_rst)
    release_edge && (next_mode == MODE_EMUL_WIDE || next_mode == MODE_SPECIAL_TEST) |=> !flash_map_enable)
    else $error("flash map enable wrong for mode");

  reset_drive_a: assert property ( // see R1
    @(posedge mclk) disable iff (sys_rst)
    internal_reset_req |=> reset_pin_n_oe && !reset_pin_n_out ##1 chip_in_reset)
    else $error("reset pin not driven low");

  strap_pullup_a: assert property ( // see R5
    @(posedge mclk) disable iff (sys_rst)
    // pin drives drop two edges after reset is seen, pull-up comes one edge after
    reset_active |=> pe7_pullup_en && (!$past(chip_in_reset) || pe_oe[PE_FREE_CYCLE] == 1'b0))
    else $error("strap pull-up missing in reset");

  rw_pin_a: assert property ( // see R10
    @(posedge mclk) disable iff (sys_rst)
    expanded && !chip_in_reset |=> pe_oe[PE_RW] && pe_out[PE_RW] == $past(ext_rw))
    else $error("read/write pin not driven");

  address_bus_a: assert property ( // see R11
    @(posedge mclk) disable iff (sys_rst)
    expanded && !chip_in_reset && ext_ad_drive |=> {pa_out, pb_out} == $past(ext_ad_out) && pa_oe == 8'hFF)
    else $error("address/data not on ports A, B");

  free_cycle_a: assert property ( // see R8
    @(posedge mclk) disable iff (sys_rst)
    expanded && !chip_in_reset && free_cycle_en && bus_idle |=> pe_out[PE_FREE_CYCLE] && pe_oe[PE_FREE_CYCLE])
    else $error("free cycle not flagged");

  tag_high_a: assert property ( // see R6
    @(posedge mclk) disable iff (sys_rst)
    expanded && tag_en && bus_clk_fall && !background_debug_pin |=> tag_high_mark)
    else $error("high half tag missed");

  irq_wake_a: assert property ( // see R12
    @(posedge mclk) disable iff (sys_rst) !pe_in[PE_IRQ] |=> irq_request && wake_request)
    else $error("maskable request did not wake");

  key_wake_a: assert property ( // see R14
    @(posedge mclk) disable iff (sys_rst)
    |kw_event |=> (key_wake_flag & $past(kw_event)) == $past(kw_event) ##1 wake_request)
    else $error("key wake flag or wake missing");

endmodule

// >>> pin_function_pkg.sv
// constants for the reset, strap and pin function block
// Functional notes
// R1: Reset pin is active low, two-way; device pulls it low on internal reset.
// R2: After reset all internal clocks come from the oscillator input.
// R3: Reset release captures background pin and port E pins 6, 5 as mode C, B, A.
// R4: Reset release latches oscillator select; 0 full swing or external, 1 loop controlled.
// R5: Oscillator select strap has a pull-up during reset, floating gives loop controlled.
// R6: Expanded with tagging, low tag-high at bus clock fall marks high instruction half.
// R7: Expanded with tagging, tag-low on port E pin 3 marks low instruction half.
// R8: Expanded and enabled, port E pin 7 flags every bus cycle the processor leaves free.
// R9: Expanded modes drive the low-byte strobe on port E pin 3; the code leaves pin 3 undriven while tagging is on.
// R10: Expanded modes drive read/write direction on port E pin 2.
// R11: Expanded modes put address/data on ports A (high) and B (low), else general purpose.
// R12: Port E pin 1 is input and maskable interrupt request, waking from stop or wait.
// R13: Port E pin 0 is input and non-maskable interrupt request, also waking the device.
// R14: Port H pins and port J pins 7, 6, 1, 0 may raise wake-up interrupts.
// R15: Port E pin 4 may output the internal bus clock as timing reference.
// R16: Port E pins 6 and 5 also carry queue tracking outputs 1 and 0.
// R17: Expanded modes use port K pin 7 as emulation chip select and flash-map strap.
// R18: Flash-map enable resets to 1 in single and peripheral modes, 0 in emulation/test.
// R19: Port H pins 7-4 serve serial unit 2, pins 3-0 serial unit 1.
// R20: Port J pins 7, 6 serve CAN unit 4 or I2C clock and data.
// R21: Port AD pins are general inputs and sixteen converter analog inputs.
// R22: Straps captured at reset release stay constant until the next reset.
// R23: Several enabled alternate functions on one pin resolve by one fixed priority.
package pin_function_pkg;
  // operating mode codes, order is mode C, B, A
  localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
  localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
  localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;
  localparam logic [2:0] MODE_EMUL_WIDE = 3'h3;
  localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
  localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
  localparam logic [2:0] MODE_PERIPH_TEST = 3'h6;
  localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;
  // reset values of captured straps
  localparam logic [2:0] MODE_RESET = MODE_SPECIAL_SINGLE;
  localparam logic OSC_SELECT_RESET = 1'b1;
  localparam logic FLASH_MAP_RESET = 1'b1;
  // oscillator select codes
  localparam logic OSC_FULL_SWING = 1'b0;
  localparam logic OSC_LOOP_CONTROLLED = 1'b1;
  // port E bit positions
  localparam int PE_FREE_CYCLE = 7;
  localparam int PE_QUEUE_1 = 6;
  localparam int PE_QUEUE_0 = 5;
  localparam int PE_BUS_CLOCK = 4;
  localparam int PE_STROBE = 3;
  localparam int PE_RW = 2;
  localparam int PE_IRQ = 1;
  localparam int PE_NONMASKABLE_INT_REQUEST = 0;
  // port J vector positions: pins 7, 6, 1, 0
  localparam int PJ_PIN7 = 3;
  localparam int PJ_PIN6 = 2;
  // key wake vector: port H in 11..4, port J in 3..0
  localparam int KEY_WAKE_COUNT = 12;
endpackage

// >>> board_straps.sv
// board side model: strap resistors, reset button and pin levels seen by the device
module board_straps
(
  input wire logic [2:0] strap_mode, // wanted mode C, B, A levels
  input wire logic osc_float, // oscillator strap left open, else tied low
  input wire logic strap_flash, // flash map strap level
  input wire logic ext_reset_low, // reset button pressed
  input wire logic [4:0] pe_low, // board levels of port E pins 4..0
  input wire logic reset_pin_n_out, // device reset drive value
  input wire logic reset_pin_n_oe, // device reset drive enable
  input wire logic [7:0] pe_out, // device port E drive values
  input wire logic [7:0] pe_oe, // device port E drive enables
  input wire logic pe7_pullup_en, // device pull-up on pin 7
  input wire logic pk7_out, // device port K pin 7 value
  input wire logic pk7_oe, // device port K pin 7 enable
  output logic background_debug_pin, // background pin level
  output logic [7:0] pe_in, // port E pin levels
  output logic pk7_in, // port K pin 7 level
  output logic reset_pin_n_in // reset pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pe7_board;
  // board pull-up on reset; device drive wins when enabled
  assign reset_pin_n_in = reset_pin_n_oe ? reset_pin_n_out : ~ext_reset_low;
  // open pin without pull-up shows no stable level
  assign pe7_board = osc_float ? (pe7_pullup_en ? 1'b1 : ~pe_out[7]) : 1'b0;
  assign background_debug_pin = strap_mode[2];
  assign pe_in = (pe_oe & pe_out) | (~pe_oe & {pe7_board, strap_mode[1:0], pe_low});
  assign pk7_in = pk7_oe ? pk7_out : strap_flash;
endmodule

// >>> reset_strap_and_pin_function_tb.sv
// self-checking bench for reset, straps and pin functions
module reset_strap_and_pin_function_tb;
  import pin_function_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk;
  logic sys_rst = 1'b1, internal_reset_req = 1'b0, pll_select = 1'b0, ext_ad_drive = 1'b0, ext_rw = 1'b0;
  logic ext_low_byte_strobe_n = 1'b1, bus_idle = 1'b0, bus_clk_level = 1'b0, emul_cs_n = 1'b1, free_cycle_en = 1'b0;
  logic queue_track_en = 1'b0, bus_clock_out_en = 1'b0, tag_en = 1'b0, serial_periph_unit_2_en = 1'b0, serial_periph_unit_1_en = 1'b0;
  logic can4_en = 1'b0, can_tx = 1'b0, i2c_en = 1'b0, i2c_scl_low = 1'b0, i2c_sda_low = 1'b0;
  logic gpio_k7_out = 1'b0, gpio_k7_dir = 1'b0, osc_float = 1'b0, strap_flash = 1'b0, ext_reset_low = 1'b0;
  logic [15:0] ext_ad_out = '0, gpio_ab_dir = '0, gpio_ab_val = '0, pad_in = '0, pad_digital_en = '0;
  logic [7:0] gpio_ab_out = '0, pa_in = '0, pb_in = '0, gpio_e_out = '0, gpio_e_dir = '0, ph_in = '0;
  logic [7:0] gpio_h_out = '0, gpio_h_dir = '0;
  logic [3:0] serial_periph_unit_2_pin_out = '0, serial_periph_unit_2_pin_oe = '0, serial_periph_unit_1_pin_out = '0, serial_periph_unit_1_pin_oe = '0, pj_in = '0;
  logic [3:0] gpio_j_out = '0, gpio_j_dir = '0;
  logic [1:0] queue_track = '0;
  logic [11:0] key_wake_en = '0, key_wake_rising = '0, key_wake_clear = '0;
  logic [2:0] strap_mode = '0;
  logic [4:0] pe_low = 5'h03;
  logic reset_pin_n_out, reset_pin_n_oe, chip_in_reset, clk_from_osc, osc_select, flash_map_enable;
  logic pe7_pullup_en, tag_high_mark, tag_low_mark, irq_request, nonmaskable_int_request_request, wake_request;
  logic pk7_out, pk7_oe, background_debug_pin, pk7_in, reset_pin_n_in, exp_flash, hi, lo;
  logic [2:0] mode;
  logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pe_in, pe_out, pe_oe, port_e_rd, ph_out, ph_oe, port_h_rd;
  logic [15:0] port_ab_rd, port_ad_rd;
  logic [3:0] pj_out, pj_oe, port_j_rd;
  logic [11:0] key_wake_flag;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  reset_strap_and_pin_function reset_strap_and_pin_function_i (.*);
  board_straps board_straps_i (.*);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait: a stuck reset must not hang the run
  task automatic wait_release();
    for (int i = 0; i < 10 && chip_in_reset !== 1'b0; i++)
      step(1);
    step(2);
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    step(20);
    check({reset_pin_n_oe, reset_pin_n_out, chip_in_reset}, 16'h0005);
    check(pe7_pullup_en, 16'h0001);
    check(clk_from_osc, 16'h0001);
    for (int m = 0; m < 8; m++)
    begin
      strap_mode = m[2:0];
      osc_float = ~m[0];
      strap_flash = ~m[1];
      sys_rst = 1'b1;
      step(20);
      sys_rst = 1'b0;
      wait_release();
      exp_flash = (m == 5 || m == 7) ? ~m[1] : (m == 0 || m == 4 || m == 6);
      check(mode, m[2:0]);
      check(osc_select, !m[0]);
      check(flash_map_enable, exp_flash);
      check(clk_from_osc, 16'h0001);
    end
    // straps moved after release must not reach the captured bits
    strap_mode = 3'h0;
    strap_flash = 1'b1;
    step(3);
    check({mode, osc_select, flash_map_enable}, 16'h001C);
    ext_ad_out = 16'hA55A;
    ext_ad_drive = 1'b1;
    ext_rw = 1'b1;
    ext_low_byte_strobe_n = 1'b0;
    {bus_idle, free_cycle_en, queue_track_en, bus_clock_out_en, bus_clk_level} = 5'h1F;
    queue_track = 2'h2;
    emul_cs_n = 1'b0;
    step(2);
    check({pa_out, pb_out}, 16'hA55A);
    check({pa_oe, pb_oe}, 16'hFFFF);
    check(pe_out[6:2], 16'h0015);
    check(pe_oe[7:0], 16'h00FC);
    check({pk7_oe, pk7_out}, 16'h0002);
    ext_rw = 1'b0;
    ext_low_byte_strobe_n = 1'b1;
    step(2);
    check(pe_out[3:2], 16'h0002);
    tag_en = 1'b1;
    step(2);
    check(pe_oe[3], 16'h0000);
    bus_clk_level = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    repeat (2)
    begin
      step(1);
      hi = hi | tag_high_mark;
      lo = lo | tag_low_mark;
    end
    check(hi, 16'h0001);
    check(lo, 16'h0001);
    pe_low = 5'h01;
    step(1);
    check({irq_request, nonmaskable_int_request_request}, 16'h0002);
    step(1);
    check(wake_request, 16'h0001);
    pe_low = 5'h02;
    step(2);
    check({irq_request, nonmaskable_int_request_request, wake_request}, 16'h0003);
    pe_low = 5'h03;
    key_wake_en[11] = 1'b1;
    key_wake_rising[11] = 1'b1;
    step(3);
    check({key_wake_flag, wake_request}, 16'h0000);
    ph_in[7] = 1'b1;
    step(1);
    check(key_wake_flag, 16'h0800);
    step(1);
    check(wake_request, 16'h0001);
    key_wake_clear[11] = 1'b1;
    step(1);
    key_wake_clear[11] = 1'b0;
    step(1);
    check(key_wake_flag, 16'h0000);
    {serial_periph_unit_2_en, serial_periph_unit_1_en} = 2'h3;
    {serial_periph_unit_2_pin_out, serial_periph_unit_1_pin_out, serial_periph_unit_2_pin_oe, serial_periph_unit_1_pin_oe} = 16'hA5F3;
    step(2);
    check({ph_out, ph_oe}, 16'hA5F3);
    {can4_en, can_tx, i2c_en} = 3'h7;
    gpio_j_dir = 4'hF;
    step(2);
    check({pj_out[3], pj_oe[3:2]}, 16'h0006);
    can4_en = 1'b0;
    i2c_scl_low = 1'b1;
    step(2);
    check({pj_out[3:2], pj_oe[3:2]}, 16'h0002);
    pad_in = 16'h1234;
    pad_digital_en = 16'h00FF;
    {pa_in, pb_in} = 16'hC33C;
    pll_select = 1'b1;
    step(2);
    check(port_ad_rd, 16'h0034);
    check(port_ab_rd, 16'hC33C);
    check({port_h_rd, port_j_rd}, 16'h0800);
    check(port_e_rd, 16'h00C3);
    check(clk_from_osc, 16'h0000);
    internal_reset_req = 1'b1;
    step(2);
    check({reset_pin_n_oe, chip_in_reset, reset_pin_n_out}, 16'h0006);
    check(clk_from_osc, 16'h0001);
    check({pa_oe, pe_oe}, 16'h0000);
    internal_reset_req = 1'b0;
    wait_release();
    ext_reset_low = 1'b1;
    step(2);
    check({chip_in_reset, reset_pin_n_oe}, 16'h0002);
    ext_reset_low = 1'b0;
    wait_release();
    check({mode, flash_map_enable}, 16'h0001);
    end_of_test();
  end
endmodule
